// ==== usb_port_seq_map.svh ====
// Register offsets, field positions, reset values and timing counts of the port sequencer
`ifndef USB_PORT_SEQ_MAP_SVH
`define USB_PORT_SEQ_MAP_SVH

`define ADDR_CTRL        8'h00
`define ADDR_STATE       8'h04
`define ADDR_XCVR        8'h08
`define ADDR_FUNC        8'h0c
`define ADDR_STATUS      8'h10
`define ADDR_MASK        8'h14

`define CTRL_CANCEL_BIT  7
`define CTRL_REQ_LSB     0
`define REQ_NONE         4'h0
`define REQ_GO_IDLE      4'h1
`define REQ_ATTACH_WAIT  4'h2

`define STATE_MON_LSB    0
`define STATE_RATE_LSB   4
`define XCVR_SEL_BIT     0
`define XCVR_TERM_BIT    1
`define XCVR_TRANSCEIVER_OPERATION_SETTING_LSB  2
`define FUNC_CONN_BIT    0
`define FUNC_DISCON_BIT  1
`define FUNC_WAKE_BIT    2
`define FUNC_CHIRP_BIT   3
`define FUNC_TXN_BIT     4
`define EVT_ATTACH_BIT   0
`define EVT_CANCEL_BIT   1

`define MON_IDLE         3'h0
`define MON_WAIT_CONNECT 3'h1
`define RATE_FS          2'h1
`define TRANSCEIVER_OPERATION_SETTING_RESET     2'h0
`define TRANSCEIVER_OPERATION_SETTING_NONDRIVE  2'h1
`define TRANSCEIVER_OPERATION_SETTING_TRANSCEIVER_OFF_SETTING 2'h3
`define LINE_SE0         2'h0
`define LINE_J           2'h1

`define CLK_MHZ          100
`define CANCEL_STOP_NS   100
`define ATTACH_FILTER_NS 2500
`define POWER_WAIT_MS    100
`define DEBOUNCE_MS      100
`define CANCEL_CYCLES    ((`CANCEL_STOP_NS * `CLK_MHZ + 999) / 1000)
`define FILTER_CYCLES    ((`ATTACH_FILTER_NS * `CLK_MHZ + 999) / 1000)
`define POWER_CYCLES     (`POWER_WAIT_MS * 1000 * `CLK_MHZ)
`define DEBOUNCE_CYCLES  (`DEBOUNCE_MS * 1000 * `CLK_MHZ)

`endif

// ==== usb_port_seq_pkg.sv ====
// Types shared by the port sequencer files
package usb_port_seq_pkg;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_STOP   = 6'b000010,
        ST_POWER  = 6'b000100,
        ST_FILTER = 6'b001000,
        ST_DEBNC  = 6'b010000,
        ST_DONE   = 6'b100000
    } seq_state_type;

    typedef struct packed {
        logic          aw_full;
        logic [7:0]    aw_addr;
        logic          w_full;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic          aw_ready;
        logic          w_ready;
        logic          ar_ready;
        logic          cancel;
        logic [3:0]    req_field;
        logic [3:0]    cancel_cnt;
        seq_state_type fsm;
        logic [2:0]    host_state;
        logic          vbus;
        logic          xcvr_sel;
        logic          term_sel;
        logic [1:0]    transceiver_operation_setting;
        logic [1:0]    rate;
        logic          txn_en;
        logic          conn_en;
        logic          discon_en;
        logic          wake_en;
        logic          chirp_en;
        logic [1:0]    status;
        logic [1:0]    mask;
        logic          irq;
        logic [1:0]    line_s1;
        logic [1:0]    line_s2;
    } seq_reg_type;

endpackage

// ==== seq_timer.sv ====
// Loadable down-counter that times the sequencer intervals
`timescale 1ns/1ps
module seq_timer
    import usb_port_seq_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    output logic                  expired
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } timer_reg_type;

    timer_reg_type s;
    timer_reg_type next_s;

    // Reload on request, otherwise count down to zero and hold
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.count = value;
        end else if (s.count != '0) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expired = (s.count == '0);

endmodule // seq_timer

// ==== usb_port_seq.sv ====
// Host port sequencer for go-idle and full-speed attach-wait with AXI4-Lite registers
`timescale 1ns/1ps
`include "usb_port_seq_map.svh"
module usb_port_seq
    import usb_port_seq_pkg::*;
#(
    parameter int TIMER_W         = 24,
    parameter int POWER_CYCLES    = `POWER_CYCLES,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    input  wire logic [1:0]  BUS_LINE_LEVEL,
    output logic             VBUS_POWER_ENABLE,
    output logic             TRANSCEIVER_SELECT,
    output logic             TERMINATION_SELECT,
    output logic [1:0]       TRANSCEIVER_OPERATION_SETTING,
    output logic [1:0]       LINK_RATE_FIELD,
    output logic             TXN_ENABLE,
    output logic             ATTACH_DETECT_ENABLE,
    output logic             DETACH_DETECT_ENABLE,
    output logic             WAKEUP_DETECT_ENABLE,
    output logic             CHIRP_DETECT_ENABLE,
    output logic             IRQ
);

    localparam logic [3:0]         CANCEL_LAST = 4'(`CANCEL_CYCLES - 1);
    localparam logic [TIMER_W-1:0] FILTER_VAL  = TIMER_W'(`FILTER_CYCLES);
    localparam logic [TIMER_W-1:0] POWER_VAL   = TIMER_W'(POWER_CYCLES);
    localparam logic [TIMER_W-1:0] DEBNC_VAL   = TIMER_W'(DEBOUNCE_CYCLES);

    seq_reg_type          s;
    seq_reg_type          next_s;
    logic                 timer_load;
    logic [TIMER_W-1:0]   timer_value;
    logic                 timer_expired;

    // One shared interval counter for supply wait, attach filter and debounce
    seq_timer #(
        .WIDTH   (TIMER_W)
    ) u_timer (
        .clk     (CLK),
        .rst     (RST),
        .load    (timer_load),
        .value   (timer_value),
        .expired (timer_expired)
    );

    // Bus slave, request decode and sequencer next state
    always_comb begin
        logic       do_write;
        logic       ctrl_write;
        logic [3:0] wr_req;
        logic [1:0] evt_set;
        logic [1:0] evt_clr;
        logic       line_j;
        logic       line_se0;
        do_write    = 1'b0;
        ctrl_write  = 1'b0;
        wr_req      = `REQ_NONE;
        evt_set     = 2'h0;
        evt_clr     = 2'h0;
        line_j      = (s.line_s2 == `LINE_J);
        line_se0    = (s.line_s2 == `LINE_SE0);
        next_s      = s;
        timer_load  = 1'b0;
        timer_value = FILTER_VAL;

        // Line level passes two flip-flops before use
        next_s.line_s1 = BUS_LINE_LEVEL;
        next_s.line_s2 = s.line_s1;

        // Address and data are taken separately, in either order
        if (S_AXI_AWVALID && !s.aw_full && !s.bvalid) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s.w_full && !s.bvalid) begin
            next_s.w_full = 1'b1;
            next_s.w_data = S_AXI_WDATA;
            next_s.w_strb = S_AXI_WSTRB;
        end
        if (s.aw_full && s.w_full) begin
            do_write       = 1'b1;
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = 2'h0;
            case (s.aw_addr)
                `ADDR_CTRL, `ADDR_STATE, `ADDR_XCVR, `ADDR_FUNC, `ADDR_STATUS, `ADDR_MASK: begin
                    next_s.bresp = 2'h0;
                end
                default: begin
                    next_s.bresp = 2'h2;
                end
            endcase
        end
        if (s.bvalid && S_AXI_BREADY) begin
            next_s.bvalid = 1'b0;
        end

        // Register writes, low byte only
        if (do_write && s.w_strb[0]) begin
            case (s.aw_addr)
                `ADDR_CTRL: begin
                    ctrl_write = 1'b1;
                    wr_req     = s.w_data[`CTRL_REQ_LSB +: 4];
                end
                `ADDR_FUNC: begin
                    next_s.wake_en  = s.w_data[`FUNC_WAKE_BIT];
                    next_s.chirp_en = s.w_data[`FUNC_CHIRP_BIT];
                    next_s.txn_en   = s.w_data[`FUNC_TXN_BIT];
                end
                `ADDR_STATUS: begin
                    evt_clr = s.w_data[1:0];
                end
                `ADDR_MASK: begin
                    next_s.mask = s.w_data[1:0];
                end
                default: begin
                    next_s.mask = s.mask;
                end
            endcase
        end

        // Stop process counts down, then the cancel bit drops by itself
        if (s.cancel) begin
            if (s.cancel_cnt == 4'h0) begin
                next_s.cancel = 1'b0;
                evt_set[`EVT_CANCEL_BIT] = 1'b1;
            end else begin
                next_s.cancel_cnt = s.cancel_cnt - 4'h1;
            end
        end

        // Sequencer progress
        case (s.fsm)
            ST_POWER: begin
                if (timer_expired) begin
                    next_s.conn_en = 1'b1;
                    next_s.fsm     = ST_FILTER;
                    timer_load     = 1'b1;
                    timer_value    = FILTER_VAL;
                end
            end
            ST_FILTER: begin
                if (!line_j) begin
                    timer_load  = 1'b1;
                    timer_value = FILTER_VAL;
                end else if (timer_expired) begin
                    next_s.discon_en = 1'b1;
                    next_s.fsm       = ST_DEBNC;
                    timer_load       = 1'b1;
                    timer_value      = DEBNC_VAL;
                end
            end
            ST_DEBNC: begin
                if (line_se0) begin
                    next_s.discon_en = 1'b0;
                    next_s.fsm       = ST_FILTER;
                    timer_load       = 1'b1;
                    timer_value      = FILTER_VAL;
                end else if (timer_expired) begin
                    evt_set[`EVT_ATTACH_BIT] = 1'b1;
                    next_s.conn_en           = 1'b0;
                    next_s.discon_en         = 1'b0;
                    next_s.fsm               = ST_DONE;
                end
            end
            ST_IDLE, ST_STOP, ST_DONE: begin
                next_s.fsm = s.fsm;
            end
            default: begin
                next_s.fsm = ST_IDLE;
            end
        endcase

        // Firmware requests override the running sequence
        if (ctrl_write) begin
            next_s.req_field = wr_req;
            if (s.w_data[`CTRL_CANCEL_BIT] && wr_req == `REQ_NONE) begin
                next_s.cancel     = 1'b1;
                next_s.cancel_cnt = CANCEL_LAST;
                next_s.fsm        = ST_STOP;
            end else if (!s.cancel && wr_req == `REQ_GO_IDLE) begin
                next_s.fsm        = ST_IDLE;
                next_s.host_state = `MON_IDLE;
                next_s.vbus       = 1'b0;
                next_s.xcvr_sel   = 1'b1;
                next_s.term_sel   = 1'b1;
                next_s.transceiver_operation_setting     = `TRANSCEIVER_OPERATION_SETTING_NONDRIVE;
                next_s.txn_en     = 1'b0;
                next_s.conn_en    = 1'b0;
                next_s.discon_en  = 1'b0;
                next_s.wake_en    = 1'b0;
                next_s.chirp_en   = 1'b0;
            end else if (!s.cancel && wr_req == `REQ_ATTACH_WAIT) begin
                next_s.fsm        = ST_POWER;
                next_s.host_state = `MON_WAIT_CONNECT;
                next_s.vbus       = 1'b1;
                next_s.xcvr_sel   = 1'b1;
                next_s.term_sel   = 1'b1;
                next_s.transceiver_operation_setting     = `TRANSCEIVER_OPERATION_SETTING_TRANSCEIVER_OFF_SETTING;
                next_s.rate       = `RATE_FS;
                next_s.conn_en    = 1'b0;
                next_s.discon_en  = 1'b0;
                timer_load        = 1'b1;
                timer_value       = POWER_VAL;
            end
        end

        // Sticky events, a new event wins over a clear
        next_s.status = (s.status & ~evt_clr) | evt_set;
        next_s.irq    = |(next_s.status & next_s.mask);

        // Read channel
        if (S_AXI_ARVALID && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = 32'h0;
            next_s.rresp  = 2'h0;
            case (S_AXI_ARADDR)
                `ADDR_CTRL: begin
                    next_s.rdata[`CTRL_CANCEL_BIT]    = s.cancel;
                    next_s.rdata[`CTRL_REQ_LSB +: 4]  = s.req_field;
                end
                `ADDR_STATE: begin
                    next_s.rdata[`STATE_MON_LSB +: 3]  = s.host_state;
                    next_s.rdata[`STATE_RATE_LSB +: 2] = s.rate;
                end
                `ADDR_XCVR: begin
                    next_s.rdata[`XCVR_SEL_BIT]         = s.xcvr_sel;
                    next_s.rdata[`XCVR_TERM_BIT]        = s.term_sel;
                    next_s.rdata[`XCVR_TRANSCEIVER_OPERATION_SETTING_LSB +: 2] = s.transceiver_operation_setting;
                end
                `ADDR_FUNC: begin
                    next_s.rdata[`FUNC_CONN_BIT]   = s.conn_en;
                    next_s.rdata[`FUNC_DISCON_BIT] = s.discon_en;
                    next_s.rdata[`FUNC_WAKE_BIT]   = s.wake_en;
                    next_s.rdata[`FUNC_CHIRP_BIT]  = s.chirp_en;
                    next_s.rdata[`FUNC_TXN_BIT]    = s.txn_en;
                end
                `ADDR_STATUS: begin
                    next_s.rdata[1:0] = s.status;
                end
                `ADDR_MASK: begin
                    next_s.rdata[1:0] = s.mask;
                end
                default: begin
                    next_s.rresp = 2'h2; // Unmapped address
                end
            endcase
        end else if (s.rvalid && S_AXI_RREADY) begin
            next_s.rvalid = 1'b0;
        end

        // Ready flags are registered so that every bus output comes from a flop
        next_s.aw_ready = !next_s.aw_full && !next_s.bvalid;
        next_s.w_ready  = !next_s.w_full && !next_s.bvalid;
        next_s.ar_ready = !next_s.rvalid;
    end

    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            s            <= '0;
            s.fsm        <= ST_IDLE;
            s.host_state <= `MON_IDLE;
            s.xcvr_sel   <= 1'b1;
            s.term_sel   <= 1'b1;
            s.transceiver_operation_setting     <= `TRANSCEIVER_OPERATION_SETTING_NONDRIVE;
            s.rate       <= `RATE_FS;
            s.aw_ready   <= 1'b1;
            s.w_ready    <= 1'b1;
            s.ar_ready   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign S_AXI_AWREADY                 = s.aw_ready;
    assign S_AXI_WREADY                  = s.w_ready;
    assign S_AXI_BVALID                  = s.bvalid;
    assign S_AXI_BRESP                   = s.bresp;
    assign S_AXI_ARREADY                 = s.ar_ready;
    assign S_AXI_RVALID                  = s.rvalid;
    assign S_AXI_RDATA                   = s.rdata;
    assign S_AXI_RRESP                   = s.rresp;
    assign VBUS_POWER_ENABLE             = s.vbus;
    assign TRANSCEIVER_SELECT            = s.xcvr_sel;
    assign TERMINATION_SELECT            = s.term_sel;
    assign TRANSCEIVER_OPERATION_SETTING = s.transceiver_operation_setting;
    assign LINK_RATE_FIELD               = s.rate;
    assign TXN_ENABLE                    = s.txn_en;
    assign ATTACH_DETECT_ENABLE          = s.conn_en;
    assign DETACH_DETECT_ENABLE          = s.discon_en;
    assign WAKEUP_DETECT_ENABLE          = s.wake_en;
    assign CHIRP_DETECT_ENABLE           = s.chirp_en;
    assign IRQ                           = s.irq;

endmodule // usb_port_seq

// ==== usb_port_seq_assertions.sv ====
// Concurrent checks on the port sequencer pins
`timescale 1ns/1ps
`include "usb_port_seq_map.svh"
module usb_port_seq_assertions #(
    parameter int POWER_CYCLES    = 200,
    parameter int DEBOUNCE_CYCLES = 300
) (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [1:0] BUS_LINE_LEVEL,
    input wire logic       VBUS_POWER_ENABLE,
    input wire logic       TRANSCEIVER_SELECT,
    input wire logic       TERMINATION_SELECT,
    input wire logic [1:0] TRANSCEIVER_OPERATION_SETTING,
    input wire logic [1:0] LINK_RATE_FIELD,
    input wire logic       TXN_ENABLE,
    input wire logic       ATTACH_DETECT_ENABLE,
    input wire logic       DETACH_DETECT_ENABLE,
    input wire logic       WAKEUP_DETECT_ENABLE,
    input wire logic       CHIRP_DETECT_ENABLE
);
    localparam int FILT = `FILTER_CYCLES;
    int vcnt;
    int jcnt;
    int dcnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Run lengths of bus power, raw J level and detach watch
    always_ff @(posedge CLK) begin
        vcnt <= (RST || !VBUS_POWER_ENABLE) ? 0 : vcnt + 1;
        jcnt <= (RST || BUS_LINE_LEVEL != `LINE_J) ? 0 : jcnt + 1;
        dcnt <= (RST || !DETACH_DETECT_ENABLE) ? 0 : dcnt + 1;
    end
    // Start of attach-wait and end of a clean debounce
    sequence powered_up;
        $rose(VBUS_POWER_ENABLE);
    endsequence
    sequence debounce_done;
        $fell(DETACH_DETECT_ENABLE) && $fell(ATTACH_DETECT_ENABLE) && VBUS_POWER_ENABLE;
    endsequence
    wait_setup_a: assert property (
        powered_up |-> TRANSCEIVER_SELECT && TERMINATION_SELECT && LINK_RATE_FIELD == `RATE_FS
        && TRANSCEIVER_OPERATION_SETTING == `TRANSCEIVER_OPERATION_SETTING_TRANSCEIVER_OFF_SETTING) else $error("wait setup wrong");
    power_hold_a: assert property (
        powered_up |-> !ATTACH_DETECT_ENABLE [*8]) else $error("attach watch too early");
    power_count_a: assert property (
        $rose(ATTACH_DETECT_ENABLE) |-> vcnt >= POWER_CYCLES) else $error("supply wait short");
    attach_powered_a: assert property (
        ATTACH_DETECT_ENABLE |-> VBUS_POWER_ENABLE) else $error("attach watch unpowered");
    filter_len_a: assert property (
        $rose(DETACH_DETECT_ENABLE) |-> jcnt >= FILT) else $error("attach filter short");
    detach_nested_a: assert property (
        DETACH_DETECT_ENABLE |-> ATTACH_DETECT_ENABLE) else $error("detach without attach");
    debounce_len_a: assert property (
        debounce_done |-> dcnt >= DEBOUNCE_CYCLES) else $error("debounce short");
    detach_drop_a: assert property (
        DETACH_DETECT_ENABLE && BUS_LINE_LEVEL == `LINE_SE0
        |-> ##[1:4] !DETACH_DETECT_ENABLE) else $error("detach not seen");
    idle_setup_a: assert property (
        $fell(VBUS_POWER_ENABLE) |-> TRANSCEIVER_SELECT && TERMINATION_SELECT
        && TRANSCEIVER_OPERATION_SETTING == `TRANSCEIVER_OPERATION_SETTING_NONDRIVE && !TXN_ENABLE
        && !ATTACH_DETECT_ENABLE && !DETACH_DETECT_ENABLE && !WAKEUP_DETECT_ENABLE
        && !CHIRP_DETECT_ENABLE) else $error("idle setup wrong");
endmodule // usb_port_seq_assertions

bind usb_port_seq usb_port_seq_assertions #(
    .POWER_CYCLES(POWER_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (
    .CLK(CLK), .RST(RST), .BUS_LINE_LEVEL(BUS_LINE_LEVEL),
    .VBUS_POWER_ENABLE(VBUS_POWER_ENABLE), .TRANSCEIVER_SELECT(TRANSCEIVER_SELECT),
    .TERMINATION_SELECT(TERMINATION_SELECT),
    .TRANSCEIVER_OPERATION_SETTING(TRANSCEIVER_OPERATION_SETTING),
    .LINK_RATE_FIELD(LINK_RATE_FIELD), .TXN_ENABLE(TXN_ENABLE),
    .ATTACH_DETECT_ENABLE(ATTACH_DETECT_ENABLE), .DETACH_DETECT_ENABLE(DETACH_DETECT_ENABLE),
    .WAKEUP_DETECT_ENABLE(WAKEUP_DETECT_ENABLE), .CHIRP_DETECT_ENABLE(CHIRP_DETECT_ENABLE)
);

// ==== usb_fs_dev_model.sv ====
// Behavioural full-speed device as seen through the host line state
`timescale 1ns/1ps
`include "usb_port_seq_map.svh"
module usb_fs_dev_model (
    input  wire logic vbus,
    input  wire logic plugged,
    output logic [1:0] line
);
    // Host pull-downs give SE0 unless a powered, plugged device pulls D+ up
    assign line = (vbus && plugged) ? `LINE_J : `LINE_SE0;
endmodule // usb_fs_dev_model

// ==== usb_port_seq_tb.sv ====
// Self-checking bench for the port sequencer
`timescale 1ns/1ps
`include "usb_port_seq_map.svh"
module usb_port_seq_tb;
    localparam int PW = 200;
    localparam int DB = 300;
    logic        clk = 0;
    logic        rst = 1;
    logic        awv = 0;
    logic        wv = 0;
    logic        br = 0;
    logic        arv = 0;
    logic        rr = 0;
    logic        plugged = 0;
    logic [7:0]  awa = 0;
    logic [7:0]  ara = 0;
    logic [31:0] wd = 0;
    logic [3:0]  ws = 0;
    logic        awr, wrd, bv, arr, rv, vbus, xs, ts, txn, att, det, wk, ch, irq;
    logic [1:0]  bresp, rresp, op, rate, line;
    logic [31:0] rdat;
    int          num_errors = 0;
    int          num_checks = 0;

    usb_fs_dev_model dev (.vbus(vbus), .plugged(plugged), .line(line));

    usb_port_seq #(.POWER_CYCLES(PW), .DEBOUNCE_CYCLES(DB)) uut (
        .CLK(clk), .RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
        .BUS_LINE_LEVEL(line), .VBUS_POWER_ENABLE(vbus), .TRANSCEIVER_SELECT(xs),
        .TERMINATION_SELECT(ts), .TRANSCEIVER_OPERATION_SETTING(op), .LINK_RATE_FIELD(rate),
        .TXN_ENABLE(txn), .ATTACH_DETECT_ENABLE(att), .DETACH_DETECT_ENABLE(det),
        .WAKEUP_DETECT_ENABLE(wk), .CHIRP_DETECT_ENABLE(ch), .IRQ(irq)
    );

    // Free-running block clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Expected register words
    function automatic logic [31:0] st_word(input logic [2:0] m);
        return {26'h0, `RATE_FS, 1'b0, m};
    endfunction
    function automatic logic [31:0] xc_word(input logic [1:0] o);
        return {28'h0, o, 2'b11};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Write with address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
        logic ah, wh, bh;
        logic [1:0] resp;
        @(posedge clk);
        awv <= 1;
        awa <= a;
        wv <= 1;
        wd <= d;
        ws <= 4'hf;
        br <= 1;
        bh = 0;
        while (!bh) begin
            @(negedge clk);
            ah = awv && awr;
            wh = wv && wrd;
            bh = bv;
            resp = bresp;
            @(posedge clk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
        end
        br <= 0;
        #1;
        chk(resp, want);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ah, got;
        @(posedge clk);
        arv <= 1;
        ara <= a;
        rr <= 1;
        got = 0;
        while (!got) begin
            @(negedge clk);
            ah = arv && arr;
            got = rv;
            d = rdat;
            resp = rresp;
            @(posedge clk);
            if (ah) arv <= 0;
        end
        rr <= 0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, want);
        chk(r, 2'h0);
    endtask

    // Counts cycles while the attach (k=0) or detach (k=1) enable stays at lvl
    task automatic hold(input bit k, input logic lvl, output int n);
        n = 0;
        while ((k ? det : att) === lvl && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard well beyond the expected run
    initial begin
        #400000;
        num_errors++;
        wrap_up();
    end

    initial begin
        int n;
        logic [31:0] d, f;
        logic [1:0] r;
        d = $urandom(32'hb036);
        repeat (6) @(posedge clk);
        rst <= 0;
        cyc(1);
        // Reset view, unmapped place, mask
        rchk(`ADDR_STATE, st_word(`MON_IDLE));
        rchk(`ADDR_XCVR, xc_word(`TRANSCEIVER_OPERATION_SETTING_NONDRIVE));
        rchk(`ADDR_FUNC, 32'h0);
        rchk(`ADDR_STATUS, 32'h0);
        rd(8'h18, d, r);
        chk(r, 2'h2);
        wr(8'h18, 32'h1, 2'h2);
        wr(`ADDR_MASK, 32'h1, 2'h0);
        $display("test reset done");
        // Attach-wait setup and supply wait
        wr(`ADDR_CTRL, {28'h0, `REQ_ATTACH_WAIT}, 2'h0);
        chk({vbus, xs, ts, op, rate}, {3'b111, `TRANSCEIVER_OPERATION_SETTING_TRANSCEIVER_OFF_SETTING, `RATE_FS});
        rchk(`ADDR_STATE, st_word(`MON_WAIT_CONNECT));
        cyc(PW - 8);
        chk(att, 1'b0);
        hold(0, 1'b0, n);
        chk(n < 20, 1'b1);
        // Short J bursts, the first just under the filter length
        for (int i = 0; i < 12; i++) begin
            plugged <= 1;
            cyc(i == 0 ? 245 : 1 + $urandom % 240);
            plugged <= 0;
            cyc(1 + $urandom % 20);
        end
        chk(det, 1'b0);
        plugged <= 1;
        hold(1, 1'b0, n);
        chk(n >= `FILTER_CYCLES && n < 300, 1'b1);
        $display("test attach filter done");
        // Detach inside the debounce restarts the filter
        cyc(100);
        plugged <= 0;
        cyc(1 + $urandom % 3);
        plugged <= 1;
        cyc(4);
        chk({att, det, irq}, 3'b100);
        hold(1, 1'b0, n);
        hold(1, 1'b1, n);
        chk(n >= DB && n < DB + 20, 1'b1);
        chk({att, det, irq}, 3'b001);
        rchk(`ADDR_STATUS, 32'h1);
        wr(`ADDR_STATUS, 32'h1, 2'h0);
        chk(irq, 1'b0);
        $display("test debounce done");
        // Host-side enables through the function register
        f = ($urandom & 32'h1c) | 32'h10;
        wr(`ADDR_FUNC, f | 32'h3, 2'h0);
        rchk(`ADDR_FUNC, f);
        chk({txn, wk, ch}, {f[4], f[2], f[3]});
        // Cancel mid supply wait, early go-idle refused, then go-idle
        wr(`ADDR_CTRL, {28'h0, `REQ_ATTACH_WAIT}, 2'h0);
        wr(`ADDR_CTRL, 32'h80, 2'h0);
        wr(`ADDR_CTRL, {28'h0, `REQ_GO_IDLE}, 2'h0);
        chk(vbus, 1'b1);
        n = 0;
        d = 32'h80;
        while (d[7] && n < 20) begin
            rd(`ADDR_CTRL, d, r);
            n++;
        end
        chk(n < 20, 1'b1);
        cyc(PW + 20);
        chk({att, irq}, 2'b00);
        rchk(`ADDR_STATUS, 32'h2);
        wr(`ADDR_MASK, 32'h3, 2'h0);
        chk(irq, 1'b1);
        wr(`ADDR_STATUS, 32'h3, 2'h0);
        chk(irq, 1'b0);
        wr(`ADDR_CTRL, {28'h0, `REQ_GO_IDLE}, 2'h0);
        chk({vbus, xs, ts, op}, {3'b011, `TRANSCEIVER_OPERATION_SETTING_NONDRIVE});
        chk({txn, att, det, wk, ch}, 5'h0);
        rd(`ADDR_STATE, d, r);
        chk(d[2:0], `MON_IDLE);
        $display("test cancel and idle done");
        wrap_up();
    end
endmodule // usb_port_seq_tb
